//--- logic/irq_ctrl_pkg.sv
// package: register map, field positions, vectors and state encodings for the interrupt controller
// Behaviour
// - timer overflow sets timer request flag, bit 6 of primary control register.
// - enabled timer flag with stack room calls 0CH, clears flag and master enable.
// - time base tick sets tick request flag, bit 4 of secondary register.
// - enabled tick flag with stack room calls 10H, clears flag and master enable.
// - rtc tick sets rtc request flag, bit 5 of secondary register.
// - enabled rtc flag with stack room calls 14H, clears flag and master enable.
// - during service, acknowledgments held until return-with-enable or enables set again.
// - return-with-enable sets master enable; plain return leaves it alone.
// - requests between two phase-two pulses are serviced on the later pulse.
// - priority ext0 04H, ext1 08H, timer 0CH, tick 10H, rtc 14H.
// - nothing serviced while master enable is clear.
// - flags stay set until serviced or cleared by software, even if disabled.
// - primary bit 0 master enable, bits 1..3 ext0, ext1, timer enables.
// - primary bits 4 and 5 ext0 and ext1 flags; bit 7 reads zero.
// - secondary bit 0 tick enable, bit 1 rtc enable.
// - secondary bits 2, 3, 6, 7 read zero.
// - external flags set on selected falling, rising or either pin edge.
// - no acknowledgment while stack full, until stack pointer decrements.
// - acknowledgment pushes only the program counter, not the status register.
package irq_ctrl_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] PRIMARY_INDEX   = 8'h0B;
  localparam logic [7:0] SECONDARY_INDEX = 8'h1E;
  localparam logic [9:0] PRIMARY_ADDR    = 10'h02C;
  localparam logic [9:0] SECONDARY_ADDR  = 10'h078;
  localparam logic [9:0] EDGE_SEL_ADDR   = 10'h100;
  localparam logic [1:0] RESP_OKAY       = 2'h0;
  localparam logic [1:0] RESP_SLVERR     = 2'h2;
  // ----------------------------------------------------------------
  // fields
  // ----------------------------------------------------------------
  localparam int MASTER_EN_BIT = 0;
  localparam int EXT0_EN_BIT   = 1;
  localparam int EXT1_EN_BIT   = 2;
  localparam int TIMER_EN_BIT  = 3;
  localparam int EXT0_FLAG_BIT = 4;
  localparam int EXT1_FLAG_BIT = 5;
  localparam int TIMER_FLAG_BIT = 6;
  localparam int TICK_EN_BIT   = 0;
  localparam int RTC_EN_BIT    = 1;
  localparam int TICK_FLAG_BIT = 4;
  localparam int RTC_FLAG_BIT  = 5;
  localparam logic [7:0] PRIMARY_MASK   = 8'h7F;
  localparam logic [7:0] SECONDARY_MASK = 8'h33;
  localparam logic [7:0] RESET_BYTE     = 8'h00;
  // edge select codes per external pin
  localparam logic [1:0] EDGE_FALL   = 2'h0;
  localparam logic [1:0] EDGE_RISE   = 2'h1;
  localparam logic [1:0] EDGE_EITHER = 2'h2;
  localparam logic [3:0] EDGE_SEL_RESET = 4'h0;
  // ----------------------------------------------------------------
  // sources, in priority order
  // ----------------------------------------------------------------
  localparam int SRC_COUNT = 5;
  localparam int SRC_EXT0  = 0;
  localparam int SRC_EXT1  = 1;
  localparam int SRC_TIMER = 2;
  localparam int SRC_TICK  = 3;
  localparam int SRC_RTC   = 4;
  localparam logic [7:0] VEC_EXT0  = 8'h04;
  localparam logic [7:0] VEC_EXT1  = 8'h08;
  localparam logic [7:0] VEC_TIMER = 8'h0C;
  localparam logic [7:0] VEC_TICK  = 8'h10;
  localparam logic [7:0] VEC_RTC   = 8'h14;
  localparam logic [7:0] VEC_NONE  = 8'h00;
  // ----------------------------------------------------------------
  // bus slave states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    BUS_IDLE = 3'b001,
    BUS_RESP = 3'b010,
    BUS_DONE = 3'b100
  } bus_state_t;
endpackage : irq_ctrl_pkg

//--- logic/irq_edge_detect.sv
// module: selectable edge detector for the two external interrupt pins
`timescale 1ns/100ps
`default_nettype none
module irq_edge_detect (
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic [1:0] pins,
  input  wire logic [3:0] edgeSel,
  output logic      [1:0] edgeHit
);
  typedef struct packed {
    logic [1:0] prev;
    logic [1:0] hit;
  } edge_state_t;
  edge_state_t state;
  edge_state_t next_state;

  always_comb begin
    next_state = state;
    next_state.prev = pins;
    for (int i = 0; i < 2; i++) begin
      logic fall;
      logic rise;
      fall = state.prev[i] & ~pins[i];
      rise = ~state.prev[i] & pins[i];
      unique case (edgeSel[2*i +: 2])
        irq_ctrl_pkg::EDGE_FALL:   next_state.hit[i] = fall;
        irq_ctrl_pkg::EDGE_RISE:   next_state.hit[i] = rise;
        irq_ctrl_pkg::EDGE_EITHER: next_state.hit[i] = fall | rise;
        default:                   next_state.hit[i] = 1'b0;
      endcase
    end
  end

  // prev resets high so a high pin after reset does not fake a rising edge
  always_ff @(posedge clock) begin
    if (reset) begin
      state <= '{prev: 2'h3, hit: 2'h0};
    end else begin
      state <= next_state;
    end
  end

  assign edgeHit = state.hit;
endmodule : irq_edge_detect
`default_nettype wire

//--- logic/irq_priority.sv
// module: fixed-priority selection of one pending enabled source
`timescale 1ns/100ps
`default_nettype none
module irq_priority (
  input  wire logic [4:0] pending,
  output logic      [4:0] grant,
  output logic      [7:0] vector
);
  logic [4:0] above;
  genvar g;
  generate
    for (g = 0; g < irq_ctrl_pkg::SRC_COUNT; g++) begin : gen_grant
      if (g == 0) begin : gen_top
        assign above[g] = 1'b0;
      end else begin : gen_rest
        assign above[g] = above[g-1] | pending[g-1];
      end
      assign grant[g] = pending[g] & ~above[g];
    end
  endgenerate

  always_comb begin
    unique case (1'b1)
      grant[irq_ctrl_pkg::SRC_EXT0]:  vector = irq_ctrl_pkg::VEC_EXT0;
      grant[irq_ctrl_pkg::SRC_EXT1]:  vector = irq_ctrl_pkg::VEC_EXT1;
      grant[irq_ctrl_pkg::SRC_TIMER]: vector = irq_ctrl_pkg::VEC_TIMER;
      grant[irq_ctrl_pkg::SRC_TICK]:  vector = irq_ctrl_pkg::VEC_TICK;
      grant[irq_ctrl_pkg::SRC_RTC]:   vector = irq_ctrl_pkg::VEC_RTC;
      default:                        vector = irq_ctrl_pkg::VEC_NONE;
    endcase
  end
endmodule : irq_priority
`default_nettype wire

//--- logic/mcu_interrupt_controller.sv
// module: interrupt controller top with AXI4-Lite register slave and core vector handshake
`timescale 1ns/100ps
`default_nettype none
module mcu_interrupt_controller (
  input  wire logic        clock,
  input  wire logic        reset,
  // AXI4-Lite slave
  input  wire logic [9:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [9:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // event sources
  input  wire logic        ext_irq_pin_a,
  input  wire logic        ext_irq_pin_b,
  input  wire logic        timerOverflow,
  input  wire logic        tickPulse,
  input  wire logic        rtcPulse,
  // core side
  input  wire logic        cycle_phase_two,
  input  wire logic        stackFull,
  input  wire logic        return_with_enable,
  output logic             irqCall,
  output logic [7:0]       irqVector
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    irq_ctrl_pkg::bus_state_t wrState;
    irq_ctrl_pkg::bus_state_t rdState;
    logic                     awHeld;
    logic                     wHeld;
    logic [9:0]               awAddr;
    logic [7:0]               wByte;
    logic                     wLane0;
    logic [1:0]               bresp;
    logic [31:0]              rdata;
    logic [1:0]               rresp;
    logic                     masterEn;
    logic [4:0]               srcEn;
    logic [4:0]               flags;
    logic [3:0]               edgeSel;
    logic                     call;
    logic [7:0]               vector;
  } ctrl_state_t;
  ctrl_state_t state;
  ctrl_state_t next_state;

  logic [1:0] edgeHit;
  logic [4:0] events;
  logic [4:0] grant;
  logic [7:0] grantVector;
  logic       wrFire;
  logic       rdFire;
  logic [7:0] primaryView;
  logic [7:0] secondaryView;

  irq_edge_detect u_edge (
    .clock   (clock),
    .reset   (reset),
    .pins    ({ext_irq_pin_b, ext_irq_pin_a}),
    .edgeSel (state.edgeSel),
    .edgeHit (edgeHit)
  );

  // only pending, enabled requests with master enable and stack room
  irq_priority u_prio (
    .pending (state.flags & state.srcEn & {5{state.masterEn & ~stackFull}}),
    .grant   (grant),
    .vector  (grantVector)
  );

  assign events = {rtcPulse, tickPulse, timerOverflow, edgeHit};

  // ----------------------------------------------------------------
  // register views
  // ----------------------------------------------------------------
  always_comb begin
    primaryView = irq_ctrl_pkg::RESET_BYTE;
    primaryView[irq_ctrl_pkg::MASTER_EN_BIT]  = state.masterEn;
    primaryView[irq_ctrl_pkg::EXT0_EN_BIT]    = state.srcEn[irq_ctrl_pkg::SRC_EXT0];
    primaryView[irq_ctrl_pkg::EXT1_EN_BIT]    = state.srcEn[irq_ctrl_pkg::SRC_EXT1];
    primaryView[irq_ctrl_pkg::TIMER_EN_BIT]   = state.srcEn[irq_ctrl_pkg::SRC_TIMER];
    primaryView[irq_ctrl_pkg::EXT0_FLAG_BIT]  = state.flags[irq_ctrl_pkg::SRC_EXT0];
    primaryView[irq_ctrl_pkg::EXT1_FLAG_BIT]  = state.flags[irq_ctrl_pkg::SRC_EXT1];
    primaryView[irq_ctrl_pkg::TIMER_FLAG_BIT] = state.flags[irq_ctrl_pkg::SRC_TIMER];
    secondaryView = irq_ctrl_pkg::RESET_BYTE;
    secondaryView[irq_ctrl_pkg::TICK_EN_BIT]   = state.srcEn[irq_ctrl_pkg::SRC_TICK];
    secondaryView[irq_ctrl_pkg::RTC_EN_BIT]    = state.srcEn[irq_ctrl_pkg::SRC_RTC];
    secondaryView[irq_ctrl_pkg::TICK_FLAG_BIT] = state.flags[irq_ctrl_pkg::SRC_TICK];
    secondaryView[irq_ctrl_pkg::RTC_FLAG_BIT]  = state.flags[irq_ctrl_pkg::SRC_RTC];
  end

  assign wrFire = (state.wrState == irq_ctrl_pkg::BUS_IDLE) & state.awHeld & state.wHeld;
  assign rdFire = (state.rdState == irq_ctrl_pkg::BUS_IDLE) & s_axi_arvalid;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] wb;
    logic [4:0] swFlags;
    logic [4:0] swFlagWr;
    wb = state.wByte;
    swFlags = state.flags;
    swFlagWr = 5'h00;
    next_state = state;
    next_state.call = 1'b0;

    // write channel: address and data taken in either order
    if (s_axi_awvalid & ~state.awHeld & (state.wrState == irq_ctrl_pkg::BUS_IDLE)) begin
      next_state.awHeld = 1'b1;
      next_state.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid & ~state.wHeld & (state.wrState == irq_ctrl_pkg::BUS_IDLE)) begin
      next_state.wHeld  = 1'b1;
      next_state.wByte  = s_axi_wdata[7:0];
      next_state.wLane0 = s_axi_wstrb[0];
    end

    unique case (state.wrState)
      irq_ctrl_pkg::BUS_IDLE: begin
        if (wrFire) begin
          next_state.wrState = irq_ctrl_pkg::BUS_RESP;
          next_state.awHeld  = 1'b0;
          next_state.wHeld   = 1'b0;
          next_state.bresp   = irq_ctrl_pkg::RESP_OKAY;
          unique case (state.awAddr)
            irq_ctrl_pkg::PRIMARY_ADDR: begin
              if (state.wLane0) begin
                next_state.masterEn = wb[irq_ctrl_pkg::MASTER_EN_BIT];
                next_state.srcEn[irq_ctrl_pkg::SRC_EXT0]  = wb[irq_ctrl_pkg::EXT0_EN_BIT];
                next_state.srcEn[irq_ctrl_pkg::SRC_EXT1]  = wb[irq_ctrl_pkg::EXT1_EN_BIT];
                next_state.srcEn[irq_ctrl_pkg::SRC_TIMER] = wb[irq_ctrl_pkg::TIMER_EN_BIT];
                swFlagWr[2:0] = 3'h7;
                swFlags[irq_ctrl_pkg::SRC_EXT0]  = wb[irq_ctrl_pkg::EXT0_FLAG_BIT];
                swFlags[irq_ctrl_pkg::SRC_EXT1]  = wb[irq_ctrl_pkg::EXT1_FLAG_BIT];
                swFlags[irq_ctrl_pkg::SRC_TIMER] = wb[irq_ctrl_pkg::TIMER_FLAG_BIT];
              end
            end
            irq_ctrl_pkg::SECONDARY_ADDR: begin
              if (state.wLane0) begin
                next_state.srcEn[irq_ctrl_pkg::SRC_TICK] = wb[irq_ctrl_pkg::TICK_EN_BIT];
                next_state.srcEn[irq_ctrl_pkg::SRC_RTC]  = wb[irq_ctrl_pkg::RTC_EN_BIT];
                swFlagWr[4:3] = 2'h3;
                swFlags[irq_ctrl_pkg::SRC_TICK] = wb[irq_ctrl_pkg::TICK_FLAG_BIT];
                swFlags[irq_ctrl_pkg::SRC_RTC]  = wb[irq_ctrl_pkg::RTC_FLAG_BIT];
              end
            end
            irq_ctrl_pkg::EDGE_SEL_ADDR: begin
              if (state.wLane0) begin
                next_state.edgeSel = wb[3:0];
              end
            end
            default: next_state.bresp = irq_ctrl_pkg::RESP_SLVERR;
          endcase
        end
      end
      irq_ctrl_pkg::BUS_RESP: begin
        if (s_axi_bready) begin
          next_state.wrState = irq_ctrl_pkg::BUS_IDLE;
        end
      end
      default: next_state.wrState = irq_ctrl_pkg::BUS_IDLE;
    endcase

    // read channel
    unique case (state.rdState)
      irq_ctrl_pkg::BUS_IDLE: begin
        if (rdFire) begin
          next_state.rdState = irq_ctrl_pkg::BUS_RESP;
          next_state.rresp   = irq_ctrl_pkg::RESP_OKAY;
          unique case (s_axi_araddr)
            irq_ctrl_pkg::PRIMARY_ADDR:   next_state.rdata = {24'h000000, primaryView};
            irq_ctrl_pkg::SECONDARY_ADDR: next_state.rdata = {24'h000000, secondaryView};
            irq_ctrl_pkg::EDGE_SEL_ADDR:  next_state.rdata = {28'h0000000, state.edgeSel};
            default: begin
              next_state.rdata = 32'h00000000;
              next_state.rresp = irq_ctrl_pkg::RESP_SLVERR;
            end
          endcase
        end
      end
      irq_ctrl_pkg::BUS_RESP: begin
        if (s_axi_rready) begin
          next_state.rdState = irq_ctrl_pkg::BUS_IDLE;
        end
      end
      default: next_state.rdState = irq_ctrl_pkg::BUS_IDLE;
    endcase

    // flags: software write, then service clear, then hardware set wins over both
    next_state.flags = (state.flags & ~swFlagWr) | (swFlags & swFlagWr);

    // a flag standing at this pulse arrived since the previous one: serve it now
    if (cycle_phase_two) begin
      if (|grant) begin
        next_state.call     = 1'b1;
        next_state.vector   = grantVector;
        next_state.masterEn = 1'b0;
        next_state.flags    = next_state.flags & ~grant;
      end
    end
    if (return_with_enable) begin
      next_state.masterEn = 1'b1;
    end
    next_state.flags = next_state.flags | events;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state <= '{wrState: irq_ctrl_pkg::BUS_IDLE, rdState: irq_ctrl_pkg::BUS_IDLE,
                 edgeSel: irq_ctrl_pkg::EDGE_SEL_RESET, default: '0};
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // write readies only while idle and the channel is not already held; read ready whenever the read side is idle
  assign s_axi_awready = (state.wrState == irq_ctrl_pkg::BUS_IDLE) & ~state.awHeld;
  assign s_axi_wready  = (state.wrState == irq_ctrl_pkg::BUS_IDLE) & ~state.wHeld;
  assign s_axi_bvalid  = (state.wrState == irq_ctrl_pkg::BUS_RESP);
  assign s_axi_bresp   = state.bresp;
  assign s_axi_arready = (state.rdState == irq_ctrl_pkg::BUS_IDLE);
  assign s_axi_rvalid  = (state.rdState == irq_ctrl_pkg::BUS_RESP);
  assign s_axi_rdata   = state.rdata;
  assign s_axi_rresp   = state.rresp;
  assign irqCall       = state.call;
  assign irqVector     = state.vector;
endmodule : mcu_interrupt_controller
`default_nettype wire

//--- verification/irq_ctrl_props.sv
// checker: port-level properties of the interrupt controller
`timescale 1ns/100ps
`default_nettype none
module irq_ctrl_props (
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        cycle_phase_two,
  input wire logic        stackFull,
  input wire logic        irqCall,
  input wire logic [7:0]  irqVector
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  chk_call_pulse: assert property (irqCall |=> !irqCall)
    else $error("call pulse wider than one cycle");
  chk_call_phase: assert property (irqCall |-> $past(cycle_phase_two))
    else $error("call not tied to a phase-two pulse");
  chk_call_room: assert property (irqCall |-> !$past(stackFull))
    else $error("call while the stack was full");
  chk_vector_set: assert property (irqCall |-> irqVector inside {[8'h04:8'h14]} && irqVector[1:0] == 2'h0)
    else $error("call with an illegal vector");
  // a reset that lasts one edge would otherwise look like a vector change
  chk_vector_cause: assert property (!$past(reset) && $changed(irqVector) |-> irqCall)
    else $error("vector changed without a call");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before handshake");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before handshake");
  chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
    else $error("write response late");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  chk_read_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:7] == 25'h0)
    else $error("unused read bits not zero");
endmodule : irq_ctrl_props
bind mcu_interrupt_controller irq_ctrl_props u_irq_ctrl_props (
  .clock, .reset, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .cycle_phase_two, .stackFull,
  .irqCall, .irqVector
);
`default_nettype wire

//--- verification/core_model.sv
// model: core sequencer with phase-two timing and a return address stack
`timescale 1ns/100ps
`default_nettype none
module core_model #(
  parameter int STACK_DEPTH = 4,
  parameter int PHASE_GAP   = 4
) (
  input  wire logic clock,
  input  wire logic reset,
  input  wire logic phaseOn,
  input  wire logic holdFull,
  input  wire logic doReturn,
  input  wire logic doPop,
  input  wire logic irqCall,
  output logic      cycle_phase_two,
  output logic      stackFull,
  output logic      return_with_enable
);
  int depth;
  int phase;
  always_ff @(posedge clock) begin
    if (reset) begin
      depth <= 0;
      phase <= 0;
      cycle_phase_two <= 1'b0;
      return_with_enable <= 1'b0;
    end else begin
      phase <= (phase == PHASE_GAP - 1) ? 0 : phase + 1;
      cycle_phase_two <= phaseOn && phase == 0;
      // only the return address is stacked; status is left to software
      depth <= depth + int'(irqCall) - int'((doReturn || doPop) && depth > 0);
      return_with_enable <= doReturn;
    end
  end
  assign stackFull = holdFull || depth >= STACK_DEPTH;
endmodule : core_model
`default_nettype wire

//--- verification/mcu_interrupt_controller_tb.sv
// testbench: registers, event flags, priority and masking of the interrupt controller
`timescale 1ns/100ps
`default_nettype none
module mcu_interrupt_controller_tb;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic [9:0]  s_axi_awaddr = 10'h000, s_axi_araddr = 10'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic ext_irq_pin_a = 1'b1, ext_irq_pin_b = 1'b1;
  logic timerOverflow = 1'b0, tickPulse = 1'b0, rtcPulse = 1'b0;
  logic phaseOn = 1'b0, holdFull = 1'b0, doReturn = 1'b0, doPop = 1'b0;
  logic cycle_phase_two, stackFull, return_with_enable, irqCall;
  logic [7:0]  irqVector;
  logic [31:0] rnd = 32'h8CD7;
  int mismatches = 0;
  int cmp_count = 0;
  int k;
  always #5 clock = ~clock;
  mcu_interrupt_controller u_mcu_interrupt_controller (
    .clock, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_irq_pin_a, .ext_irq_pin_b,
    .timerOverflow, .tickPulse, .rtcPulse, .cycle_phase_two, .stackFull,
    .return_with_enable, .irqCall, .irqVector
  );
  core_model u_core_model (
    .clock, .reset, .phaseOn, .holdFull, .doReturn, .doPop, .irqCall,
    .cycle_phase_two, .stackFull, .return_with_enable
  );
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  // flags of the first three sources stay until their own turn
  function automatic logic [7:0] exp_pri(input int n);
    exp_pri = 8'h0E;
    for (int i = 0; i < 3; i++) if (i >= n) exp_pri[4 + i] = 1'b1;
  endfunction : exp_pri
  function automatic logic [7:0] exp_sec(input int n);
    return {2'h0, n < 5, n < 4, 4'h3};
  endfunction : exp_sec
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_sim
  task automatic timeout();
    mismatches++;
    $display("MISMATCH t=%0t wait limit reached", $time);
    end_sim();
  endtask : timeout
  task automatic note(input bit ok, input string kind, input logic [31:0] g, e);
    cmp_count++;
    if (!ok) begin
      mismatches++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, kind, g, e);
    end
  endtask : note
  task automatic cmp_reg(input logic [31:0] g, e);
    note(g === e, "register", g, e);
  endtask : cmp_reg
  task automatic cmp_resp(input logic [1:0] g, e);
    note(g === e, "response", {30'h0, g}, {30'h0, e});
  endtask : cmp_resp
  task automatic cmp_evt(input logic [7:0] g, e);
    note(g === e, "vector or count", {24'h0, g}, {24'h0, e});
  endtask : cmp_evt
  // ready is awaited late on purpose so the slave must hold its answer
  task automatic axi_write(input logic [9:0] a, input logic [7:0] d, output logic [1:0] r);
    int n;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) break;
      if (s_axi_bvalid) s_axi_bready <= 1'b1;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n == 40) timeout();
  endtask : axi_write
  task automatic axi_read(input logic [9:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
      if (s_axi_rvalid) s_axi_rready <= 1'b1;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n == 40) timeout();
  endtask : axi_read
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
    cmp_resp(r, irq_ctrl_pkg::RESP_OKAY);
  endtask : wr
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(a, d, r);
    cmp_reg(d, {24'h0, e});
    cmp_resp(r, irq_ctrl_pkg::RESP_OKAY);
  endtask : rd
  task automatic wait_call(input logic [7:0] e);
    int n;
    for (n = 0; n < 60; n++) begin
      @(posedge clock);
      if (irqCall) break;
    end
    if (n == 60) timeout();
    cmp_evt(irqVector, e);
  endtask : wait_call
  task automatic quiet(input int cycles);
    logic [7:0] c;
    c = 8'h00;
    repeat (cycles) begin
      @(posedge clock);
      if (irqCall) c++;
    end
    cmp_evt(c, 8'h00);
  endtask : quiet
  task automatic ret(input bit withEnable);
    @(posedge clock);
    if (withEnable) doReturn <= 1'b1;
    else doPop <= 1'b1;
    @(posedge clock);
    doReturn <= 1'b0;
    doPop <= 1'b0;
  endtask : ret
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    rd(irq_ctrl_pkg::PRIMARY_ADDR, 8'h00);
    rd(irq_ctrl_pkg::SECONDARY_ADDR, 8'h00);
    axi_read(10'h3F0, d, r);
    cmp_resp(r, irq_ctrl_pkg::RESP_SLVERR);
    axi_write(10'h3F0, 8'hFF, r);
    cmp_resp(r, irq_ctrl_pkg::RESP_SLVERR);
    $display("test reset_and_map done");
    for (k = 0; k < 6; k++) begin
      rnd = xs(rnd);
      wr(irq_ctrl_pkg::PRIMARY_ADDR, rnd[7:0]);
      wr(irq_ctrl_pkg::SECONDARY_ADDR, rnd[15:8]);
      rd(irq_ctrl_pkg::PRIMARY_ADDR, rnd[7:0] & 8'h7F);
      rd(irq_ctrl_pkg::SECONDARY_ADDR, rnd[15:8] & 8'h33);
    end
    wr(irq_ctrl_pkg::PRIMARY_ADDR, 8'h00);
    wr(irq_ctrl_pkg::SECONDARY_ADDR, 8'h00);
    $display("test register_fields done");
    wr(irq_ctrl_pkg::EDGE_SEL_ADDR, 8'h04);
    @(posedge clock);
    {timerOverflow, tickPulse, rtcPulse} <= 3'h7;
    {ext_irq_pin_a, ext_irq_pin_b} <= 2'h0;
    @(posedge clock);
    {timerOverflow, tickPulse, rtcPulse} <= 3'h0;
    @(posedge clock);
    ext_irq_pin_b <= 1'b1;
    // a pin edge takes two clock edges to reach its flag
    @(posedge clock);
    rd(irq_ctrl_pkg::PRIMARY_ADDR, 8'h70);
    rd(irq_ctrl_pkg::SECONDARY_ADDR, 8'h30);
    wr(irq_ctrl_pkg::PRIMARY_ADDR, 8'h00);
    rd(irq_ctrl_pkg::PRIMARY_ADDR, 8'h00);
    wr(irq_ctrl_pkg::EDGE_SEL_ADDR, 8'h06);
    ext_irq_pin_a <= 1'b1;
    @(posedge clock);
    rd(irq_ctrl_pkg::PRIMARY_ADDR, 8'h10);
    s_axi_wstrb <= 4'hE;
    wr(irq_ctrl_pkg::PRIMARY_ADDR, 8'hFF);
    s_axi_wstrb <= 4'hF;
    rd(irq_ctrl_pkg::PRIMARY_ADDR, 8'h10);
    $display("test event_flags done");
    wr(irq_ctrl_pkg::PRIMARY_ADDR, 8'h7F);
    wr(irq_ctrl_pkg::SECONDARY_ADDR, 8'h33);
    phaseOn <= 1'b1;
    for (k = 1; k <= 5; k++) begin
      wait_call(8'(4 * k));
      rd(irq_ctrl_pkg::PRIMARY_ADDR, exp_pri(k));
      rd(irq_ctrl_pkg::SECONDARY_ADDR, exp_sec(k));
      if (k == 1) quiet(20);
      if (k < 5) ret(1'b1);
    end
    ret(1'b0);
    rd(irq_ctrl_pkg::PRIMARY_ADDR, 8'h0E);
    $display("test priority_service done");
    wr(irq_ctrl_pkg::PRIMARY_ADDR, 8'h48);
    quiet(16);
    holdFull <= 1'b1;
    wr(irq_ctrl_pkg::PRIMARY_ADDR, 8'h49);
    quiet(16);
    holdFull <= 1'b0;
    wait_call(8'h0C);
    rd(irq_ctrl_pkg::PRIMARY_ADDR, 8'h08);
    $display("test masking_and_stack done");
    end_sim();
  end
endmodule : mcu_interrupt_controller_tb
`default_nettype wire
